// ==== include/uart_cfg_map.svh ====
// Purpose: offsets, reset values, field positions and codes of the config block
// Assumes: byte-wide registers, word index offsets scaled by stride outside
// Notes: included by bare name
`ifndef UART_CFG_MAP_SVH
`define UART_CFG_MAP_SVH
`define OFS_DIV_LOW 4'h0
`define OFS_DIV_HIGH 4'h1
`define OFS_IDENT 4'h2
`define OFS_LINE_CTRL 4'h3
`define OFS_MODEM_CTRL 4'h4
`define OFS_RESUME_TWO 4'h5
`define OFS_THRESH 4'h6
`define OFS_TRIGGER 4'h7
`define OFS_IRQ_ENABLE 4'h8
`define OFS_FIFO_CTRL 4'h9
`define OFS_SUPP_CFG 4'ha
`define OFS_MODE_SEL 4'hb
`define LCR_ENHANCED_KEY 8'hbf
`define LCR_DIV_ACCESS 7
`define MCR_THRESH_ACCESS 6
`define EFR_AUTO_CTS 7
`define EFR_AUTO_RTS 6
`define EFR_SPECIAL_CHAR 5
`define EFR_ENHANCED_EN 4
`define SCR_TX_GRAN 6
`define SCR_RX_GRAN 7
`define FCR_FIFO_EN 0
`define THRESH_RESET 8'h0f
`define DIV_HIGH_MASK 8'h3f
`define IER_PROTECT_MASK 8'hf0
`define FCR_PROTECT_MASK 8'h30
`define MCR_PROTECT_MASK 8'he0
`define IIR_NONE 8'h01
`define SRC_CODE_LINE 5'h03
`define SRC_CODE_RX_TIMEOUT 5'h06
`define SRC_CODE_RX 5'h02
`define SRC_CODE_TX 5'h01
`define SRC_CODE_SPECIAL 5'h08
`endif

// ==== include/uart_cfg_pkg.sv ====
// Purpose: shared types of the config block
// Assumes: nothing
// Notes: constants live in uart_cfg_map.svh
package uart_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] level_t;
  typedef enum logic {MODE_UART, MODE_INFRARED} link_mode_e;
endpackage : uart_cfg_pkg

// ==== sim/modem_far_end.sv ====
// Purpose: behavioural modem on the serial side
// Assumes: characters arrive already assembled
// Notes: char lines show the inverse of the last byte between strobes
`timescale 1ns/100ps
module modem_far_end
(
  // clock
  input wire logic clk,
  // modem lines
  output logic cts_n,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  initial
  begin
    cts_n = 1'b0;
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  task automatic set_cts(input logic level_n);
    @(posedge clk);
    cts_n <= level_n;
  endtask : set_cts
  task automatic send(input logic [7:0] ch);
    @(posedge clk);
    rx_char <= ch;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~ch;
  endtask : send
endmodule : modem_far_end

// ==== sim/test_uart_irq_flow_config.sv ====
// Purpose: self-checking bench of the interrupt, flow and config block
// Assumes: 125 MHz clock, register port with one-cycle read data
// Notes: register sequences with expected values
`timescale 1ns/100ps
module test_uart_irq_flow_config
  import uart_cfg_pkg::*;
;
  logic ref_clk, rst, ce, wr, rd, rx_timeout, dma_mode, rx_valid, cts_n;
  logic rts_n, tx_allow, dma_req, irq_n, sleep_en;
  logic [3:0] addr, flow_sel;
  byte_t wdata, irq_src, rdata, rx_char;
  logic [6:0] fill;
  logic [13:0] baud;
  level_t tx_lvl, rx_lvl;
  int num_errors = 0;
  int checked = 0;

  uart_irq_flow_config u_dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_SOURCES(irq_src),
    .RX_TIMEOUT(rx_timeout), .RX_CHAR_VALID(rx_valid), .RX_CHAR(rx_char),
    .RX_FIFO_COUNT(fill), .DMA_MODE(dma_mode), .CTS_N(cts_n), .RTS_N(rts_n),
    .TX_ALLOW(tx_allow), .RX_DMA_REQ(dma_req), .IRQ_REQUEST_N(irq_n), .BAUD_DIVISOR(baud),
    .SLEEP_EN(sleep_en), .SOFT_FLOW_SELECT(flow_sel), .TX_TRIGGER_LEVEL(tx_lvl),
    .RX_TRIGGER_LEVEL(rx_lvl));
  modem_far_end u_far (.clk(ref_clk), .cts_n(cts_n), .rx_valid(rx_valid), .rx_char(rx_char));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string w, input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input byte_t d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input byte_t exp, input string w);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(w, 14'(rdata), 14'(exp));
  endtask : rd_chk
  task automatic drive_src(input byte_t s, input logic t);
    @(posedge ref_clk);
    irq_src <= s;
    rx_timeout <= t;
    @(negedge ref_clk);
  endtask : drive_src

  // run limit well above the sequence length
  initial
  begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    byte_t codes[6] = '{8'h00, 8'h08, 8'h04, 8'h0c, 8'h02, 8'h03};
    byte_t srcs[4] = '{8'h02, 8'h01, 8'h03, 8'h43};
    byte_t ids[4] = '{8'hc2, 8'hc4, 8'hcc, 8'hc6};
    level_t txc[4] = '{6'd8, 6'd16, 6'd32, 6'd56};
    level_t rxc[4] = '{6'd8, 6'd16, 6'd56, 6'd60};
    logic [6:0] fills[4] = '{7'd0, 7'd20, 7'd12, 7'd8};
    logic rts_exp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    irq_src = 8'h00;
    rx_timeout = 1'b0;
    dma_mode = 1'b0;
    fill = 7'd0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("irq_n", 14'(irq_n), 14'h1);
    chk("tx_lvl", 14'(tx_lvl), 14'd8);
    chk("rx_lvl", 14'(rx_lvl), 14'd8);
    rd_chk(4'h2, 8'h01, "ident");
    rd_chk(4'hf, 8'h00, "unmapped");
    // write while the enable is low must not land
    @(posedge ref_clk);
    ce <= 1'b0;
    wr_reg(4'h7, 8'h5a);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd_chk(4'h7, 8'h00, "ce_hold");
    wr_reg(4'h7, 8'h5a);
    rd_chk(4'h7, 8'h5a, "scratch");
    wr_reg(4'h8, 8'hff);
    rd_chk(4'h8, 8'h0f, "ier_locked");
    wr_reg(4'h3, 8'hbf);
    wr_reg(4'h2, 8'h10);
    rd_chk(4'h2, 8'h10, "feature");
    for (int i = 4; i < 8; i++)
      wr_reg(i[3:0], 8'h30 + i[7:0]);
    for (int i = 4; i < 8; i++)
      rd_chk(i[3:0], 8'h30 + i[7:0], "xon_xoff");
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(4'h2, codes[i] | 8'h10);
      chk("flow_sel", 14'(flow_sel), 14'(codes[i]));
    end
    wr_reg(4'h3, 8'h80);
    wr_reg(4'h0, 8'h34);
    wr_reg(4'h1, 8'hff);
    chk("baud", baud, 14'h3f34);
    rd_chk(4'h1, 8'h3f, "div_high");
    wr_reg(4'h3, 8'h03);
    rd_chk(4'h2, 8'h01, "ident");
    wr_reg(4'h8, 8'hff);
    rd_chk(4'h8, 8'hff, "ier_open");
    chk("sleep_en", 14'(sleep_en), 14'h1);
    wr_reg(4'h9, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      drive_src(srcs[i], i > 1);
      rd_chk(4'h2, ids[i], "ident_uart");
      chk("irq_n", 14'(irq_n), 14'h0);
    end
    wr_reg(4'h8, 8'h01);
    drive_src(8'h02, 1'b0);
    rd_chk(4'h2, 8'hc1, "tx_gated");
    chk("irq_n", 14'(irq_n), 14'h1);
    drive_src(8'h00, 1'b1);
    rd_chk(4'h2, 8'hcc, "timeout");
    wr_reg(4'h8, 8'h02);
    rd_chk(4'h2, 8'hc1, "timeout_gated");
    drive_src(8'h00, 1'b0);
    wr_reg(4'h3, 8'hbf);
    wr_reg(4'h2, 8'h30);
    wr_reg(4'h3, 8'h03);
    wr_reg(4'h8, 8'h20);
    dma_mode <= 1'b1;
    u_far.send(8'h36);
    rd_chk(4'h2, 8'hc1, "no_match");
    u_far.send(8'h37);
    rd_chk(4'h2, 8'hd0, "special");
    rd_chk(4'h2, 8'hc1, "special_clr");
    wr_reg(4'h4, 8'h40);
    rd_chk(4'h6, 8'h0f, "thresh_rst");
    wr_reg(4'h6, 8'h25);
    rd_chk(4'h6, 8'h25, "thresh");
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(4'h9, {k[1:0], k[1:0], 4'h1});
      chk("tx_code", 14'(tx_lvl), 14'(txc[k]));
      chk("rx_code", 14'(rx_lvl), 14'(rxc[k]));
    end
    wr_reg(4'h7, 8'h35);
    chk("tx_fine", 14'(tx_lvl), 14'd20);
    chk("rx_fine", 14'(rx_lvl), 14'd12);
    wr_reg(4'ha, 8'hc0);
    chk("tx_cat", 14'(tx_lvl), 14'd23);
    chk("rx_cat", 14'(rx_lvl), 14'd15);
    wr_reg(4'h3, 8'hbf);
    wr_reg(4'h2, 8'hd0);
    wr_reg(4'h3, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      fill <= fills[i];
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("rts_n", 14'(rts_n), 14'(rts_exp[i]));
    end
    u_far.set_cts(1'b1);
    @(negedge ref_clk);
    chk("tx_halt", 14'(tx_allow), 14'h0);
    u_far.set_cts(1'b0);
    @(negedge ref_clk);
    chk("tx_go", 14'(tx_allow), 14'h1);
    wr_reg(4'h3, 8'hbf);
    wr_reg(4'h2, 8'h10);
    wr_reg(4'h3, 8'h03);
    u_far.set_cts(1'b1);
    @(negedge ref_clk);
    chk("tx_free", 14'(tx_allow), 14'h1);
    wr_reg(4'hb, 8'h01);
    wr_reg(4'h8, 8'h00);
    drive_src(8'h24, 1'b0);
    chk("irq_n", 14'(irq_n), 14'h1);
    wr_reg(4'h8, 8'h20);
    chk("irq_n", 14'(irq_n), 14'h0);
    wr_reg(4'h8, 8'hff);
    rd_chk(4'h2, 8'h24, "ident_ir");
    tally_and_finish();
  end
endmodule : test_uart_irq_flow_config

// ==== sim/uart_irq_flow_config_chk.sv ====
// Purpose: port-level checks of the interrupt, flow and config block
// Assumes: one clock, synchronous reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module uart_irq_flow_config_chk
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // events and modem lines
  input wire logic [7:0] IRQ_SOURCES,
  input wire logic RX_TIMEOUT,
  input wire logic RX_CHAR_VALID,
  input wire logic DMA_MODE,
  input wire logic CTS_N,
  input wire logic TX_ALLOW,
  input wire logic RX_DMA_REQ,
  input wire logic IRQ_REQUEST_N,
  // configuration
  input wire logic [13:0] BAUD_DIVISOR,
  input wire logic SLEEP_EN,
  input wire logic [3:0] SOFT_FLOW_SELECT,
  input wire logic [5:0] TX_TRIGGER_LEVEL
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  dma_per_byte_a: assert property (RX_DMA_REQ == (DMA_MODE && RX_CHAR_VALID))
    else $error("dma request differs from received byte strobe");
  cts_halt_a: assert property (!TX_ALLOW |-> CTS_N)
    else $error("transmit halted while clear-to-send active");
  irq_cause_a: assert property ($fell(IRQ_REQUEST_N) |-> (|IRQ_SOURCES) || RX_TIMEOUT
    || $past(RX_CHAR_VALID) || $past(WR))
    else $error("interrupt request without a cause");
  sleep_gate_a: assert property ($rose(SLEEP_EN) |-> $past(WR) && $past(ADDR) == 4'h8
    && $past(WDATA[4]))
    else $error("sleep enable set without enable write");
  flow_sel_a: assert property ($changed(SOFT_FLOW_SELECT) |-> $past(WR)
    && $past(ADDR) == 4'h2 && $past(WDATA[3:0]) == SOFT_FLOW_SELECT)
    else $error("flow select differs from written value");
  divisor_write_a: assert property ($changed(BAUD_DIVISOR) |-> $past(WR)
    && $past(ADDR) <= 4'h1)
    else $error("divisor changed without latch write");
  trigger_write_a: assert property ($changed(TX_TRIGGER_LEVEL) |-> $past(WR))
    else $error("transmit trigger changed without write");
  read_slot_a: assert property ($past(CE) && !$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its slot");

  cover property ($fell(IRQ_REQUEST_N));
  cover property (!TX_ALLOW);
  cover property (RX_DMA_REQ);
endmodule : uart_irq_flow_config_chk

bind uart_irq_flow_config uart_irq_flow_config_chk u_chk (.REF_CLK, .RST, .CE, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .IRQ_SOURCES, .RX_TIMEOUT, .RX_CHAR_VALID, .DMA_MODE, .CTS_N, .TX_ALLOW,
  .RX_DMA_REQ, .IRQ_REQUEST_N, .BAUD_DIVISOR, .SLEEP_EN, .SOFT_FLOW_SELECT, .TX_TRIGGER_LEVEL);

// ==== src/uart_irq_flow_config.sv ====
// Purpose: interrupt, flow-control and configuration registers of a UART/IrDA controller
// Assumes: plain register port, read data one cycle after read strobe
// Notes: datapaths outside; events arrive as levels or pulses on the status ports
//
// Contract
// RULE_01 - UART mode: enable bit 1 gates TX holding, bit 0 RX holding and time-out.
// RULE_02 - IrDA modes: eight individual interrupt enables, bit 7 down to bit 0.
// RULE_03 - Software reads mode-definition-two bit 0 after a TX status interrupt.
// RULE_04 - UART identify register read-only; source in 5:1, bits 7:6 copy FIFO enable.
// RULE_05 - Interrupt output active when any interrupt active; pending bit low-true, resets 1.
// RULE_06 - IrDA identify shows one active-high bit per source, resets zero.
// RULE_07 - Offset 2 reads identify unless line control is 0xBF, then enhanced feature.
// RULE_08 - Auto-CTS set: transmitter halts while clear-to-send input is high.
// RULE_09 - Auto-RTS: RTS goes high at halt level, low again at restore level.
// RULE_10 - Special-char detect: match on second XOFF stored and sets identify bit 4.
// RULE_11 - Enhanced enable clear ignores writes to protected INTERRUPT_ENABLE_UART, FIFO_CONTROL_REG, MODEM_CONTROL_REG bits.
// RULE_12 - Bits 3:2 select transmit soft flow, 1:0 receive comparison pairs.
// RULE_13 - Software keeps both XON characters different when soft flow enabled.
// RULE_14 - Two XON registers serve as address registers in IrDA modes, reset zero.
// RULE_15 - Offsets 6 and 7 reach threshold/trigger only with enhanced and MODEM_CONTROL_REG bit 6.
// RULE_16 - Fourteen-bit divisor from low latch and six-bit high latch at 0 and 1.
// RULE_17 - Software writes divisor latches only before enabling sleep mode.
// RULE_18 - Threshold register: restore 7:4 reset 0, halt 3:0 reset 0xF, times four.
// RULE_19 - Software keeps halt threshold above restore threshold with flow control.
// RULE_20 - One DMA request per received byte in DMA mode with flow control.
// RULE_21 - TX trigger from FIFO code, field times four, or six-bit concatenation.
// RULE_22 - RX trigger from FIFO-control 7:6 code when field zero and bit 7 clear.
// RULE_23 - RX trigger field times four, or six-bit concatenation with bit 7 set.
// RULE_24 - Fixed code per source; report highest-priority enabled pending source.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "uart_cfg_map.svh"
module uart_irq_flow_config
  import uart_cfg_pkg::*;
#(
  parameter int FIFO_DEPTH_BITS = 7
)
(
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // interrupt sources, levels
  input wire logic [7:0] IRQ_SOURCES,
  input wire logic RX_TIMEOUT,
  // receive side
  input wire logic RX_CHAR_VALID,
  input wire logic [7:0] RX_CHAR,
  input wire logic [FIFO_DEPTH_BITS-1:0] RX_FIFO_COUNT,
  input wire logic DMA_MODE,
  // modem lines
  input wire logic CTS_N,
  output logic RTS_N,
  output logic TX_ALLOW,
  output logic RX_DMA_REQ,
  output logic IRQ_REQUEST_N,
  // configuration outputs
  output logic [13:0] BAUD_DIVISOR,
  output logic SLEEP_EN,
  output logic [3:0] SOFT_FLOW_SELECT,
  output logic [5:0] TX_TRIGGER_LEVEL,
  output logic [5:0] RX_TRIGGER_LEVEL
);
  byte_t line_control_reg;
  byte_t modem_control_reg;
  byte_t fifo_control_reg;
  byte_t supplementary_config_reg;
  byte_t irq_enable_reg;
  byte_t enhanced_feature_reg;
  byte_t flow_threshold_reg;
  byte_t trigger_level_reg;
  byte_t scratch_reg;
  byte_t divisor_low_reg;
  byte_t divisor_high_latch;
  byte_t resume_one_reg;
  byte_t resume_two_reg;
  byte_t pause_one_reg;
  byte_t pause_two_reg;
  byte_t rdata_reg;
  byte_t rdata_next;
  logic special_char_reg;
  logic rts_high_reg;
  link_mode_e mode_reg;
  logic [4:0] irq_source_code;
  logic irq_pending_n;
  byte_t irda_active;
  byte_t ident_value;
  logic enhanced_key;
  logic enhanced_en;
  logic thresh_access;
  logic [FIFO_DEPTH_BITS+1:0] halt_bytes;
  logic [FIFO_DEPTH_BITS+1:0] restore_bytes;
  logic [FIFO_DEPTH_BITS+1:0] fifo_count_wide;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic byte_t guarded(input byte_t old, input byte_t nw, input byte_t mask,
                                    input logic en);
    guarded = en ? nw : ((old & mask) | (nw & ~mask));
  endfunction : guarded

  assign enhanced_key = (line_control_reg == `LCR_ENHANCED_KEY);
  assign enhanced_en = enhanced_feature_reg[`EFR_ENHANCED_EN];
  assign thresh_access = enhanced_en && modem_control_reg[`MCR_THRESH_ACCESS]; // RULE_15

  // line control, modem control, fifo control, supplementary config, mode
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      line_control_reg <= 8'h00;
      modem_control_reg <= 8'h00;
      fifo_control_reg <= 8'h00;
      supplementary_config_reg <= 8'h00;
      mode_reg <= MODE_UART;
    end
    else if (CE && WR)
    begin
      if (hit(ADDR, `OFS_LINE_CTRL))
      begin
        line_control_reg <= WDATA;
      end
      if (hit(ADDR, `OFS_MODEM_CTRL) && !enhanced_key)
      begin
        modem_control_reg <= guarded(modem_control_reg, WDATA, `MCR_PROTECT_MASK,
                                     enhanced_en); // RULE_11
      end
      if (hit(ADDR, `OFS_FIFO_CTRL))
      begin
        fifo_control_reg <= guarded(fifo_control_reg, WDATA, `FCR_PROTECT_MASK,
                                    enhanced_en); // RULE_11
      end
      if (hit(ADDR, `OFS_SUPP_CFG))
      begin
        supplementary_config_reg <= WDATA;
      end
      if (hit(ADDR, `OFS_MODE_SEL))
      begin
        mode_reg <= WDATA[0] ? MODE_INFRARED : MODE_UART;
      end
    end
  end

  // interrupt enable and enhanced feature
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      irq_enable_reg <= 8'h00; // RULE_01
      enhanced_feature_reg <= 8'h00;
    end
    else if (CE && WR)
    begin
      if (hit(ADDR, `OFS_IRQ_ENABLE))
      begin
        irq_enable_reg <= guarded(irq_enable_reg, WDATA, `IER_PROTECT_MASK,
                                  enhanced_en || (mode_reg == MODE_INFRARED)); // RULE_11
      end
      if (hit(ADDR, `OFS_IDENT) && enhanced_key)
      begin
        enhanced_feature_reg <= WDATA; // RULE_07
      end
    end
  end

  // divisor latches
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      divisor_low_reg <= 8'h00;
      divisor_high_latch <= 8'h00;
    end
    else if (CE && WR && line_control_reg[`LCR_DIV_ACCESS])
    begin
      if (hit(ADDR, `OFS_DIV_LOW))
      begin
        divisor_low_reg <= WDATA; // RULE_16
      end
      if (hit(ADDR, `OFS_DIV_HIGH))
      begin
        divisor_high_latch <= WDATA & `DIV_HIGH_MASK; // RULE_16
      end
    end
  end

  // characters, addresses, thresholds, scratch
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      resume_one_reg <= 8'h00; // RULE_14
      resume_two_reg <= 8'h00;
      pause_one_reg <= 8'h00;
      pause_two_reg <= 8'h00;
      flow_threshold_reg <= `THRESH_RESET; // RULE_18
      trigger_level_reg <= 8'h00;
      scratch_reg <= 8'h00;
    end
    else if (CE && WR)
    begin
      if (enhanced_key && hit(ADDR, `OFS_MODEM_CTRL))
      begin
        resume_one_reg <= WDATA;
      end
      if (enhanced_key && hit(ADDR, `OFS_RESUME_TWO))
      begin
        resume_two_reg <= WDATA;
      end
      if (hit(ADDR, `OFS_THRESH))
      begin
        if (thresh_access)
        begin
          flow_threshold_reg <= WDATA; // RULE_15
        end
        else if (enhanced_key)
        begin
          pause_one_reg <= WDATA;
        end
      end
      if (hit(ADDR, `OFS_TRIGGER))
      begin
        if (thresh_access)
        begin
          trigger_level_reg <= WDATA;
        end
        else if (enhanced_key)
        begin
          pause_two_reg <= WDATA;
        end
        else
        begin
          scratch_reg <= WDATA;
        end
      end
    end
  end

  // special character flag: set wins over the read that clears it
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      special_char_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (RX_CHAR_VALID && enhanced_feature_reg[`EFR_SPECIAL_CHAR] &&
          RX_CHAR == pause_two_reg && mode_reg == MODE_UART)
      begin
        special_char_reg <= 1'b1; // RULE_10
      end
      else if (RD && hit(ADDR, `OFS_IDENT) && !enhanced_key)
      begin
        special_char_reg <= 1'b0;
      end
    end
  end

  // auto-RTS hysteresis on receive FIFO fill
  assign halt_bytes = (FIFO_DEPTH_BITS+2)'({flow_threshold_reg[3:0], 2'b00}); // RULE_18
  assign restore_bytes = (FIFO_DEPTH_BITS+2)'({flow_threshold_reg[7:4], 2'b00});
  assign fifo_count_wide = (FIFO_DEPTH_BITS+2)'(RX_FIFO_COUNT);
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rts_high_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (!enhanced_feature_reg[`EFR_AUTO_RTS])
      begin
        rts_high_reg <= 1'b0;
      end
      else if (fifo_count_wide >= halt_bytes)
      begin
        rts_high_reg <= 1'b1; // RULE_09
      end
      else if (fifo_count_wide <= restore_bytes)
      begin
        rts_high_reg <= 1'b0; // RULE_09
      end
    end
  end

  // interrupt priority, uart mode
  always_comb
  begin
    irq_source_code = 5'h00;
    irq_pending_n = 1'b1;
    if (IRQ_SOURCES[6] && irq_enable_reg[2])
    begin
      irq_source_code = `SRC_CODE_LINE; // RULE_24
      irq_pending_n = 1'b0;
    end
    else if (RX_TIMEOUT && irq_enable_reg[0])
    begin
      irq_source_code = `SRC_CODE_RX_TIMEOUT; // RULE_01
      irq_pending_n = 1'b0;
    end
    else if (IRQ_SOURCES[0] && irq_enable_reg[0])
    begin
      irq_source_code = `SRC_CODE_RX; // RULE_01
      irq_pending_n = 1'b0;
    end
    else if (IRQ_SOURCES[1] && irq_enable_reg[1])
    begin
      irq_source_code = `SRC_CODE_TX; // RULE_01
      irq_pending_n = 1'b0;
    end
    else if (special_char_reg && irq_enable_reg[5])
    begin
      irq_source_code = `SRC_CODE_SPECIAL; // RULE_10
      irq_pending_n = 1'b0;
    end
  end

  assign irda_active = IRQ_SOURCES & irq_enable_reg; // RULE_02 RULE_06

  always_comb
  begin
    if (mode_reg == MODE_INFRARED)
    begin
      ident_value = irda_active; // RULE_06
    end
    else
    begin
      ident_value = {{2{fifo_control_reg[`FCR_FIFO_EN]}}, irq_source_code,
                     irq_pending_n}; // RULE_04
    end
  end

  // read mux
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (ADDR)
      `OFS_DIV_LOW: rdata_next = line_control_reg[`LCR_DIV_ACCESS] ? divisor_low_reg : 8'h00;
      `OFS_DIV_HIGH: rdata_next = line_control_reg[`LCR_DIV_ACCESS] ? divisor_high_latch
                                                                    : 8'h00;
      `OFS_IDENT: rdata_next = enhanced_key ? enhanced_feature_reg : ident_value; // RULE_07
      `OFS_LINE_CTRL: rdata_next = line_control_reg;
      `OFS_MODEM_CTRL: rdata_next = enhanced_key ? resume_one_reg : modem_control_reg;
      `OFS_RESUME_TWO: rdata_next = enhanced_key ? resume_two_reg : 8'h00;
      `OFS_THRESH: rdata_next = thresh_access ? flow_threshold_reg
                              : (enhanced_key ? pause_one_reg : 8'h00);
      `OFS_TRIGGER: rdata_next = thresh_access ? trigger_level_reg
                               : (enhanced_key ? pause_two_reg : scratch_reg); // RULE_15
      `OFS_IRQ_ENABLE: rdata_next = irq_enable_reg;
      `OFS_FIFO_CTRL: rdata_next = fifo_control_reg;
      `OFS_SUPP_CFG: rdata_next = supplementary_config_reg;
      `OFS_MODE_SEL: rdata_next = {7'h00, mode_reg == MODE_INFRARED};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rdata_reg <= 8'h00;
    end
    else if (CE)
    begin
      rdata_reg <= RD ? rdata_next : 8'h00;
    end
  end

  // trigger level selection
  uart_trigger_select #(
    .CODE0(6'd8),
    .CODE1(6'd16),
    .CODE2(6'd32),
    .CODE3(6'd56)
  ) tx_trigger (
    .fine_sel(supplementary_config_reg[`SCR_TX_GRAN]),
    .level_field(trigger_level_reg[3:0]),
    .coarse_code(fifo_control_reg[5:4]),
    .level(TX_TRIGGER_LEVEL)
  ); // RULE_21

  uart_trigger_select #(
    .CODE0(6'd8),
    .CODE1(6'd16),
    .CODE2(6'd56),
    .CODE3(6'd60)
  ) rx_trigger (
    .fine_sel(supplementary_config_reg[`SCR_RX_GRAN]),
    .level_field(trigger_level_reg[7:4]),
    .coarse_code(fifo_control_reg[7:6]),
    .level(RX_TRIGGER_LEVEL)
  ); // RULE_22 RULE_23

  assign RDATA = rdata_reg;
  assign IRQ_REQUEST_N = (mode_reg == MODE_INFRARED) ? (irda_active == 8'h00)
                                                      : irq_pending_n; // RULE_05
  assign RTS_N = enhanced_feature_reg[`EFR_AUTO_RTS] ? rts_high_reg
                                                     : ~modem_control_reg[1];
  assign TX_ALLOW = !(enhanced_feature_reg[`EFR_AUTO_CTS] && CTS_N); // RULE_08
  assign RX_DMA_REQ = DMA_MODE && RX_CHAR_VALID; // RULE_20
  assign BAUD_DIVISOR = {divisor_high_latch[5:0], divisor_low_reg}; // RULE_16
  assign SLEEP_EN = irq_enable_reg[4];
  assign SOFT_FLOW_SELECT = enhanced_feature_reg[3:0]; // RULE_12
endmodule : uart_irq_flow_config

// ==== src/uart_trigger_select.sv ====
// Purpose: picks one FIFO trigger level from fine field, coarse code and granularity
// Assumes: coarse code table is a parameter set per direction
// Notes: a zero fine field without fine granularity falls back to the coarse code table
`timescale 1ns/100ps
module uart_trigger_select
  import uart_cfg_pkg::*;
#(
  parameter logic [5:0] CODE0 = 6'd8,
  parameter logic [5:0] CODE1 = 6'd16,
  parameter logic [5:0] CODE2 = 6'd32,
  parameter logic [5:0] CODE3 = 6'd56
)
(
  // selection inputs
  input wire logic fine_sel,
  input wire logic [3:0] level_field,
  input wire logic [1:0] coarse_code,
  // result
  output level_t level
);
  always_comb
  begin
    if (fine_sel)
    begin
      level = {level_field, coarse_code};
    end
    else if (level_field != 4'h0)
    begin
      level = {level_field, 2'b00};
    end
    else
    begin
      unique case (coarse_code)
        2'b00: level = CODE0;
        2'b01: level = CODE1;
        2'b10: level = CODE2;
        2'b11: level = CODE3;
      endcase
    end
  end
endmodule : uart_trigger_select
